// >>> logic/mam_mapper.sv
// Purpose: translate core logical code/data accesses to 32-bit addresses
// Assumes: core signals come from logic on aclk; AXI4-Lite registers
// Notes:   one bus cycle pulse per forwarded access, one cycle later
`timescale 1ns/100ps

module mam_mapper
  import mam_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input  logic              aclk,
  input  logic              aresetn,
  // AXI4-Lite write channels
  input  logic [ADDR_W-1:0] awaddr,
  input  logic              awvalid,
  output logic              awready,
  input  logic [31:0]       wdata,
  input  logic [3:0]        wstrb,
  input  logic              wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  logic              bready,
  // AXI4-Lite read channels
  input  logic [ADDR_W-1:0] araddr,
  input  logic              arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  logic              rready,
  // Core access
  input  logic              core_req,
  input  mam_space_t        core_space,
  input  logic              core_opcode,
  input  logic              core_internal,
  input  logic [15:0]       core_addr,
  // System bus address
  output logic              bus_valid,
  output logic [31:0]       bus_addr,
  output logic [1:0]        bus_src,
  output mam_region_t       bus_region
);

  // Every assertion below samples on aclk and sleeps while reset is held
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // Register file
  logic [7:0]  cfg_reg [MAM_NCFG];
  logic [31:0] last_pa_reg;
  logic [7:0]  last_in_reg;

  // Slot of a configuration index inside cfg_reg
  function automatic int slot(input logic [15:0] idx);
    return int'(idx - MAM_IDX_ROM_TAR);
  endfunction

  function automatic logic [15:0] idx_of(input logic [ADDR_W-1:0] a);
    return 16'(a >> 2);
  endfunction

  function automatic logic is_cfg(input logic [15:0] idx);
    return (idx >= MAM_IDX_ROM_TAR) && (idx <= MAM_IDX_D0_TAR);
  endfunction

  function automatic logic is_stat(input logic [15:0] idx);
    return (idx == MAM_IDX_LAST_PA) || (idx == MAM_IDX_LAST_IN);
  endfunction

  // ==========================================================
  // Write channel: address and data taken in either order
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [15:0] aw_idx_reg;
  logic [7:0]  wbyte_reg;
  logic        wlane_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        aw_have;
  logic        w_have;
  logic        wr_go;
  logic [15:0] wr_idx;
  logic [7:0]  wr_byte;
  logic        wr_lane;

  assign awready = !aw_got_reg && !bvalid_reg;
  assign wready  = !w_got_reg && !bvalid_reg;
  assign aw_have = aw_got_reg || (awvalid && awready);
  assign w_have  = w_got_reg || (wvalid && wready);
  assign wr_go   = aw_have && w_have && !bvalid_reg;
  assign wr_idx  = aw_got_reg ? aw_idx_reg : idx_of(awaddr);
  assign wr_byte = w_got_reg ? wbyte_reg : wdata[7:0];
  assign wr_lane = w_got_reg ? wlane_reg : wstrb[0];
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;

  // Hold whichever half arrived first until the other joins it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      aw_idx_reg <= 16'h0000;
      wbyte_reg  <= 8'h00;
      wlane_reg  <= 1'b0;
    end else if (wr_go) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_got_reg <= 1'b1;
        aw_idx_reg <= idx_of(awaddr);
      end
      if (wvalid && wready) begin
        w_got_reg <= 1'b1;
        wbyte_reg <= wdata[7:0];
        wlane_reg <= wstrb[0];
      end
    end
  end

  // Write response; status words are read-only and ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= MAM_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (is_cfg(wr_idx) || is_stat(wr_idx)) ? MAM_RESP_OKAY
                                                        : MAM_RESP_DECERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Configuration bytes; programmable mappers come up disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < MAM_NCFG; i++) begin
        cfg_reg[i] <= MAM_RST_BYTE;
      end
    end else if (wr_go && wr_lane && is_cfg(wr_idx)) begin
      cfg_reg[slot(wr_idx)] <= wr_byte;
    end
  end

  // ==========================================================
  // Read channel: one read at a time
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [15:0] rd_idx;

  assign arready = !rvalid_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;
  assign rd_idx  = idx_of(araddr);

  // Unmapped words read as zero with a decode error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= MAM_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= MAM_RESP_OKAY;
      if (is_cfg(rd_idx)) begin
        rdata_reg <= {24'h000000, cfg_reg[slot(rd_idx)]};
      end else if (rd_idx == MAM_IDX_LAST_PA) begin
        rdata_reg <= last_pa_reg;
      end else if (rd_idx == MAM_IDX_LAST_IN) begin
        rdata_reg <= {24'h000000, last_in_reg};
      end else begin
        rdata_reg <= 32'h00000000;
        rresp_reg <= MAM_RESP_DECERR;
      end
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Mapper settings
  mam_map_if mif [MAM_NMAP] ();
  logic [MAM_NMAP-1:0] hit_w;
  logic [31:0]         phys_w [MAM_NMAP];
  logic [7:0]          rom_top;

  // Top byte tells opcode fetches from operand fetches when debugging
  assign rom_top = core_opcode ? cfg_reg[slot(MAM_IDX_ROM_ALT)]
                               : cfg_reg[slot(MAM_IDX_ROM_TAR)];

  // ROM mapper: 1K zone matched everywhere, so 64 copies
  assign mif[MAM_ROM_ID].zone       = 8'h00;
  assign mif[MAM_ROM_ID].size       = MAM_ROM_SIZE;
  assign mif[MAM_ROM_ID].target     = {rom_top, MAM_ROM_TGT};
  assign mif[MAM_ROM_ID].en         = 1'b1;
  assign mif[MAM_ROM_ID].always_hit = 1'b1;

  // RAM data mapper: whole data space onto the on-chip RAM
  assign mif[MAM_D0_ID].zone       = 8'h00;
  assign mif[MAM_D0_ID].size       = MAM_RAM_SIZE;
  assign mif[MAM_D0_ID].target     = {cfg_reg[slot(MAM_IDX_D0_TAR)],
                                      MAM_RAM_TGT};
  assign mif[MAM_D0_ID].en         = 1'b1;
  assign mif[MAM_D0_ID].always_hit = 1'b1;

  // Programmable code mappers share one register layout
  for (genvar g = MAM_C1_ID; g <= MAM_C2_ID; g++) begin : g_prog
    localparam logic [15:0] B = (g == MAM_C1_ID) ? MAM_IDX_C1_BASE
                                                 : MAM_IDX_C2_BASE;
    logic [7:0] ctl;
    logic [7:0] top;
    assign ctl = cfg_reg[slot(B + 16'(MAM_OFS_CTL))];
    assign top = core_opcode ? cfg_reg[slot(B + 16'(MAM_OFS_ALT))]
                             : cfg_reg[slot(B + 16'(MAM_OFS_TAR2))];
    assign mif[g].zone       = cfg_reg[slot(B + 16'(MAM_OFS_SRC))];
    assign mif[g].size       = ctl[4:0];
    assign mif[g].target     = {top,
                                cfg_reg[slot(B + 16'(MAM_OFS_TAR1))],
                                cfg_reg[slot(B + 16'(MAM_OFS_TAR0))]};
    assign mif[g].en         = ctl[MAM_CTL_EN];
    assign mif[g].always_hit = 1'b0;
  end

  // ==========================================================
  // Comparators, one per mapper
  for (genvar g = 0; g < MAM_NMAP; g++) begin : g_map
    assign mif[g].addr  = core_addr;
    assign mif[g].space = core_space;
    assign hit_w[g]     = mif[g].hit;
    assign phys_w[g]    = mif[g].phys;
    mam_zone_cmp #(
      .MAP_SPACE ((g == MAM_D0_ID) ? MAM_DATA : MAM_CODE)
    ) u_cmp (
      .m (mif[g])
    );
  end

  // ==========================================================
  // Priority: the last hit in slot order wins
  logic        sel_hit;
  logic [1:0]  sel_id;
  logic [31:0] sel_pa;

  always_comb begin
    sel_hit = 1'b0;
    sel_id  = 2'h0;
    sel_pa  = 32'h00000000;
    for (int i = 0; i < MAM_NMAP; i++) begin
      if (hit_w[i]) begin
        sel_hit = 1'b1;
        sel_id  = 2'(i);
        sel_pa  = phys_w[i];
      end
    end
  end

  // Region as dedicated resources see it: only bits 23:0 count
  function automatic mam_region_t region_of(input logic [23:0] pa);
    if (pa >= MAM_PA_EXT) begin
      return MAM_RG_EXTMEM;
    end
    if (pa >= MAM_PA_USER) begin
      return MAM_RG_USER;
    end
    if (pa >= MAM_PA_RSVD) begin
      return MAM_RG_RSVD;
    end
    if (pa >= MAM_PA_CRU) begin
      return MAM_RG_CRU;
    end
    if (pa >= MAM_PA_RAM) begin
      return MAM_RG_RAM;
    end
    return MAM_RG_ROM;
  endfunction

  // ==========================================================
  // Bus outputs; internal accesses and SFRs never reach the bus
  logic        go;
  logic        bus_valid_reg;
  logic [31:0] bus_addr_reg;
  logic [1:0]  bus_src_reg;
  mam_region_t bus_region_reg;

  assign go = core_req && !core_internal && sel_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_valid_reg  <= 1'b0;
      bus_addr_reg   <= 32'h00000000;
      bus_src_reg    <= 2'h0;
      bus_region_reg <= MAM_RG_ROM;
    end else begin
      bus_valid_reg <= go;
      if (go) begin
        bus_addr_reg   <= sel_pa;
        bus_src_reg    <= sel_id;
        bus_region_reg <= region_of(sel_pa[23:0]);
      end
    end
  end

  assign bus_valid  = bus_valid_reg;
  assign bus_addr   = bus_addr_reg;
  assign bus_src    = bus_src_reg;
  assign bus_region = bus_region_reg;

  // Last forwarded access, for software to inspect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_pa_reg <= 32'h00000000;
      last_in_reg <= 8'h00;
    end else if (go) begin
      last_pa_reg                          <= sel_pa;
      last_in_reg[MAM_IN_SEEN]             <= 1'b1;
      last_in_reg[MAM_IN_SRC+:2]           <= sel_id;
      last_in_reg[MAM_IN_RG+:3]            <= region_of(sel_pa[23:0]);
    end
  end

  // ==========================================================
  // Assertions

  AST_SPACE: assert property (core_req && !core_internal
      && core_space == MAM_SFR |=> !bus_valid)
    else $error("SFR access reached the bus");
  AST_INTERNAL: assert property (core_req && core_internal
      |=> !bus_valid)
    else $error("internal access forwarded");
  AST_LOW_BYTE: assert property (go |=>
      bus_addr[7:0] == $past(core_addr[7:0]))
    else $error("low byte not passed through");
  AST_ROM_TOP: assert property (go && sel_id == 2'h0
      && core_opcode |=> bus_addr[31:24] == $past(cfg_reg[1]))
    else $error("opcode fetch lacks opcode target byte");
  AST_ROM_RANGE: assert property (bus_valid && bus_src == 2'h0
      |-> bus_addr[23:10] == 14'h0000 && bus_region == MAM_RG_ROM)
    else $error("ROM access outside its 1K copy");
  AST_CODE_HIT: assert property (core_req && !core_internal
      && core_space == MAM_CODE |=> bus_valid && bus_src != 2'h3)
    else $error("code fetch not mapped");
  AST_RESET_OFF: assert property ($rose(aresetn) |->
      !mif[1].en && !mif[2].en)
    else $error("programmable mapper enabled after reset");
  AST_PRIO: assert property (core_req && !core_internal
      && hit_w[2] |=> bus_src == 2'h2)
    else $error("lower-priority mapper won overlap");
  AST_BHOLD: assert property (bvalid && !bready |=> bvalid[*2]
      or (bvalid ##1 !bvalid))
    else $error("write response dropped early");

  COV_ROM_OP: cover property (go && sel_id == 2'h0 && core_opcode);
  COV_C2: cover property (go && sel_id == 2'h2 && hit_w[1]);
  COV_DATA: cover property (go && sel_id == 2'h3);
  COV_WR: cover property (wr_go ##1 bvalid && bready);

endmodule

// >>> logic/mam_pkg.sv
// Purpose: shared types and constants of the code/data address mapper
// Assumes: a single aclk domain; AXI4-Lite register access
// Notes:   register indices are word indices, byte address = 4 * index
package mam_pkg;

  // ==========================================================
  // Access spaces and physical regions
  typedef enum logic [1:0] {MAM_CODE, MAM_DATA, MAM_SFR} mam_space_t;
  typedef enum logic [2:0] {
    MAM_RG_ROM, MAM_RG_RAM, MAM_RG_CRU, MAM_RG_RSVD, MAM_RG_USER, MAM_RG_EXTMEM
  } mam_region_t;

  // ==========================================================
  // Mapper slots; a higher slot wins within one space
  localparam int MAM_NMAP  = 4;
  localparam int MAM_ROM_ID = 0;
  localparam int MAM_C1_ID = 1;
  localparam int MAM_C2_ID = 2;
  localparam int MAM_D0_ID = 3;

  // ==========================================================
  // Register indices
  localparam logic [15:0] MAM_IDX_ROM_TAR = 16'hff00;
  localparam logic [15:0] MAM_IDX_ROM_ALT = 16'hff01;
  localparam logic [15:0] MAM_IDX_C1_BASE = 16'hff02;
  localparam logic [15:0] MAM_IDX_C2_BASE = 16'hff08;
  localparam logic [15:0] MAM_IDX_D0_TAR  = 16'hff0e;
  localparam logic [15:0] MAM_IDX_LAST_PA = 16'hff20;
  localparam logic [15:0] MAM_IDX_LAST_IN = 16'hff21;
  // Field bytes of a programmable code mapper, relative to its base
  localparam logic [3:0]  MAM_OFS_TAR0 = 4'h0;
  localparam logic [3:0]  MAM_OFS_TAR1 = 4'h1;
  localparam logic [3:0]  MAM_OFS_TAR2 = 4'h2;
  localparam logic [3:0]  MAM_OFS_SRC  = 4'h3;
  localparam logic [3:0]  MAM_OFS_CTL  = 4'h4;
  localparam logic [3:0]  MAM_OFS_ALT  = 4'h5;
  localparam int          MAM_CTL_EN   = 5;
  localparam int          MAM_NCFG     = 15;
  localparam logic [7:0]  MAM_RST_BYTE = 8'h00;

  // ==========================================================
  // Zone sizes and fixed targets (target bits 15:0 of the 24)
  localparam logic [4:0]  MAM_SIZE_MIN = 5'h08;
  localparam logic [4:0]  MAM_SIZE_MAX = 5'h10;
  localparam logic [4:0]  MAM_ROM_SIZE = 5'h0a;
  localparam logic [4:0]  MAM_RAM_SIZE = 5'h10;
  localparam logic [15:0] MAM_ROM_TGT  = 16'h0000;
  localparam logic [15:0] MAM_RAM_TGT  = 16'h0100;

  // ==========================================================
  // Physical region lower bounds on bits 23:0
  localparam logic [23:0] MAM_PA_RAM  = 24'h010000;
  localparam logic [23:0] MAM_PA_CRU  = 24'h020000;
  localparam logic [23:0] MAM_PA_RSVD = 24'h030000;
  localparam logic [23:0] MAM_PA_USER = 24'h100000;
  localparam logic [23:0] MAM_PA_EXT  = 24'h800000;

  // ==========================================================
  // Last-access info layout and bus responses
  localparam int         MAM_IN_SEEN = 0;
  localparam int         MAM_IN_SRC  = 1;
  localparam int         MAM_IN_RG   = 3;
  localparam logic [1:0] MAM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MAM_RESP_DECERR = 2'h3;

endpackage

// >>> logic/mam_map_if.sv
// Purpose: bundle between the mapper top and one zone comparator
// Assumes: purely combinational traffic on aclk
// Notes:   cfg side drives settings and the access, cmp side answers
`timescale 1ns/100ps
interface mam_map_if;
  import mam_pkg::*;
  logic [7:0]  zone;
  logic [4:0]  size;
  logic [23:0] target;
  logic        en;
  logic        always_hit;
  logic [15:0] addr;
  mam_space_t  space;
  logic        hit;
  logic [31:0] phys;
  modport cfg (output zone, size, target, en, always_hit, addr, space,
               input hit, phys);
  modport cmp (input zone, size, target, en, always_hit, addr, space,
               output hit, phys);
endinterface

// >>> logic/mam_zone_cmp.sv
// Purpose: one address mapper: zone compare and address translation
// Assumes: size programmed 8..16; out-of-range values are clamped
// Notes:   combinational; the top picks among several of these
`timescale 1ns/100ps
module mam_zone_cmp
  import mam_pkg::*;
#(
  parameter mam_space_t MAP_SPACE = MAM_CODE
) (
  // Settings and access in, hit and address out
  mam_map_if.cmp m
);

  logic [4:0]  size_c;
  logic [15:0] mask16;
  logic [7:0]  msk;
  logic        same_zone;

  // ==========================================================
  // Mask from zone size; clamping keeps a bad size from going wild
  always_comb begin
    size_c = m.size;
    if (size_c < MAM_SIZE_MIN) begin
      size_c = MAM_SIZE_MIN;
    end
    if (size_c > MAM_SIZE_MAX) begin
      size_c = MAM_SIZE_MAX;
    end
  end

  assign mask16 = 16'((17'h00001 << size_c) - 17'h00001);
  assign msk    = mask16[15:8];

  // ==========================================================
  // Compare upper byte only, masked bits ignored
  assign same_zone = ((m.addr[15:8] ^ m.zone) & ~msk) == 8'h00;
  assign m.hit = (m.space == MAP_SPACE) && m.en
                 && (m.always_hit || same_zone);

  // Target on 31:8, masked logical bits and low byte pass through
  assign m.phys = {m.target[23:8],
                   (m.target[7:0] & ~msk) | (m.addr[15:8] & msk),
                   m.addr[7:0]};

endmodule

// >>> verif/mam_core_model.sv
// Purpose: core-side partner; issues logical accesses, logs the bus side
// Assumes: one access per cycle while core_req is high
// Notes:   each log entry holds {src, region, address} of one forwarded access
`timescale 1ns/100ps
module mam_core_model
  import mam_pkg::*;
(
  // Clock
  input  logic        aclk,
  // Core access out
  output logic        core_req,
  output mam_space_t  core_space,
  output logic        core_opcode,
  output logic        core_internal,
  output logic [15:0] core_addr,
  // System bus in
  input  logic        bus_valid,
  input  logic [31:0] bus_addr,
  input  logic [1:0]  bus_src,
  input  mam_region_t bus_region
);
  logic [36:0] seen_q[$];

  // ==========================================================
  // Access driving
  initial begin
    core_req      = 1'b0;
    core_space    = MAM_CODE;
    core_opcode   = 1'b0;
    core_internal = 1'b0;
    core_addr     = 16'h0000;
  end

  // One access per call; calls back to back give one access per cycle
  task automatic access(input mam_space_t sp, input logic op, input logic intl,
                        input logic [15:0] a);
    @(posedge aclk);
    core_req      <= 1'b1;
    core_space    <= sp;
    core_opcode   <= op;
    core_internal <= intl;
    core_addr     <= a;
  endtask

  // Idle address is inverted so a stale value can never look valid
  task automatic idle();
    @(posedge aclk);
    core_req  <= 1'b0;
    core_addr <= ~core_addr;
  endtask

  // ==========================================================
  // Log every forwarded access for later comparison
  always @(posedge aclk) begin
    if (bus_valid === 1'b1) begin
      seen_q.push_back({bus_src, bus_region, bus_addr});
    end
  end
endmodule

// >>> verif/tb_top.sv
// Purpose: self-checking bench of the address mapper
// Assumes: AXI4-Lite master tasks; core partner drives logical accesses
// Notes:   register byte address is four times the word index
`timescale 1ns/100ps
module tb_top;
  import mam_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [17:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, core_req, core_opcode, core_internal;
  logic bus_valid;
  logic [1:0]  bresp, rresp, bus_src;
  logic [31:0] rdata, bus_addr;
  logic [15:0] core_addr;
  mam_space_t  core_space;
  mam_region_t bus_region;
  int err_total = 0, n_checks = 0, cyc = 0;
  logic [31:0] rd;
  logic [1:0]  rs;

  // ==========================================================
  // Clock, design and partner
  always #2 aclk = ~aclk;

  mam_mapper #(.ADDR_W(18)) uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .core_req(core_req), .core_space(core_space),
    .core_opcode(core_opcode), .core_internal(core_internal), .core_addr(core_addr),
    .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_src(bus_src),
    .bus_region(bus_region));

  mam_core_model core (.aclk(aclk), .core_req(core_req), .core_space(core_space),
    .core_opcode(core_opcode), .core_internal(core_internal), .core_addr(core_addr),
    .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_src(bus_src),
    .bus_region(bus_region));

  // ==========================================================
  // Reporting
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  // ==========================================================
  // AXI4-Lite master; handshakes sampled just before the taking edge
  task automatic axi_wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r,
                        input logic late = 1'b0);
    logic a, w, ah, wh;
    a = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= !late;
    while (!(a && w)) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      @(posedge aclk);
      if (ah) begin
        awvalid <= 1'b0;
        a = 1'b1;
      end
      if (wh) begin
        wvalid <= 1'b0;
        w = 1'b1;
      end
    end
    // A late taker leaves the response waiting, so its hold is exercised
    if (late) begin
      @(posedge aclk);
      bready <= 1'b1;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic ah;
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge aclk);
      ah = arvalid && arready;
      @(posedge aclk);
    end while (!ah);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    axi_wr(idx, d, rs);
    chk(rs, MAM_RESP_OKAY);
  endtask

  // ==========================================================
  // Core accesses and the bus log
  task automatic expect_q(input logic [36:0] e);
    if (core.seen_q.size() == 0) chk(40'h0, {3'h0, e});
    else chk(core.seen_q.pop_front(), {3'h0, e});
  endtask

  task automatic settle();
    core.idle();
    repeat (2) @(posedge aclk);
  endtask

  task automatic fetch(input mam_space_t sp, input logic op, input logic [15:0] a,
                       input logic [36:0] e);
    core.access(sp, op, 1'b0, a);
    settle();
    expect_q(e);
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(MAM_IDX_ROM_TAR, rd, rs);
    chk({rs, rd}, {MAM_RESP_OKAY, 32'h0});
    fetch(MAM_CODE, 1'b1, 16'h1234, {2'd0, MAM_RG_ROM, 32'h00000234});
    wr(MAM_IDX_ROM_TAR, 8'ha5);
    wr(MAM_IDX_ROM_ALT, 8'h5a);
    axi_rd(MAM_IDX_ROM_ALT, rd, rs);
    chk({rs, rd}, {MAM_RESP_OKAY, 32'h0000005a});
    fetch(MAM_CODE, 1'b0, 16'h1234, {2'd0, MAM_RG_ROM, 32'ha5000234});
    fetch(MAM_CODE, 1'b1, 16'hfe34, {2'd0, MAM_RG_ROM, 32'h5a000234});
    fetch(MAM_DATA, 1'b0, 16'h8123, {2'd3, MAM_RG_RAM, 32'h00018123});
    core.access(MAM_DATA, 1'b0, 1'b1, 16'h0040);
    core.access(MAM_SFR, 1'b0, 1'b0, 16'h0090);
    settle();
    chk(40'(core.seen_q.size()), 40'h0);
    // First code mapper: target 11_80_40, zone 20, 4K zone (size 12)
    wr(MAM_IDX_C1_BASE + 16'h0, 8'h40);
    wr(MAM_IDX_C1_BASE + 16'h1, 8'h80);
    wr(MAM_IDX_C1_BASE + 16'h2, 8'h11);
    wr(MAM_IDX_C1_BASE + 16'h3, 8'h20);
    wr(MAM_IDX_C1_BASE + 16'h4, 8'h2c);
    wr(MAM_IDX_C1_BASE + 16'h5, 8'h22);
    core.access(MAM_CODE, 1'b0, 1'b0, 16'h2abc);
    core.access(MAM_CODE, 1'b1, 1'b0, 16'h2abc);
    core.access(MAM_CODE, 1'b0, 1'b0, 16'h30bc);
    settle();
    expect_q({2'd1, MAM_RG_EXTMEM, 32'h11804abc});
    expect_q({2'd1, MAM_RG_EXTMEM, 32'h22804abc});
    expect_q({2'd0, MAM_RG_ROM, 32'ha50000bc});
    fetch(MAM_DATA, 1'b0, 16'h2abc, {2'd3, MAM_RG_RAM, 32'h00012abc});
    // Second code mapper covers all of code space and lands in user space
    wr(MAM_IDX_C2_BASE + 16'h0, 8'h00);
    wr(MAM_IDX_C2_BASE + 16'h1, 8'h10);
    wr(MAM_IDX_C2_BASE + 16'h2, 8'h00);
    wr(MAM_IDX_C2_BASE + 16'h3, 8'h00);
    wr(MAM_IDX_C2_BASE + 16'h4, 8'h30);
    fetch(MAM_CODE, 1'b0, 16'h2abc, {2'd2, MAM_RG_USER, 32'h00102abc});
    // Status words answer OKAY to a write but keep their value
    wr(MAM_IDX_LAST_PA, 8'hff);
    axi_rd(MAM_IDX_LAST_PA, rd, rs);
    chk({rs, rd}, {MAM_RESP_OKAY, 32'h00102abc});
    axi_rd(MAM_IDX_LAST_IN, rd, rs);
    chk({rs, rd}, {MAM_RESP_OKAY, 26'h0, MAM_RG_USER, 2'd2, 1'b1});
    axi_rd(16'h0100, rd, rs);
    chk({rs, rd}, {MAM_RESP_DECERR, 32'h0});
    axi_wr(16'h0100, 8'h77, rs, 1'b1);
    chk(rs, MAM_RESP_DECERR);
    end_of_test();
  end
endmodule
